// ===== fbt_consts.svh
// Purpose: named constants of the fieldbus bus timing block
// Assumes: 50 MHz system clock
// Notes:   speed codes are 0..9, slowest first
`ifndef FBT_CONSTS_SVH
`define FBT_CONSTS_SVH

// transmission speed codes
`define FBT_SPD_9K6     4'h0
`define FBT_SPD_19K2    4'h1
`define FBT_SPD_45K45   4'h2
`define FBT_SPD_93K75   4'h3
`define FBT_SPD_187K5   4'h4
`define FBT_SPD_500K    4'h5
`define FBT_SPD_1M5     4'h6
`define FBT_SPD_3M      4'h7
`define FBT_SPD_6M      4'h8
`define FBT_SPD_12M     4'h9
`define FBT_SPD_DEFAULT `FBT_SPD_1M5

// phase increments: round(rate * 2^32 / 50e6)
`define FBT_INC_9K6     32'd824634
`define FBT_INC_19K2    32'd1649267
`define FBT_INC_45K45   32'd3904125
`define FBT_INC_93K75   32'd8053064
`define FBT_INC_187K5   32'd16106127
`define FBT_INC_500K    32'd42949673
`define FBT_INC_1M5     32'd128849019
`define FBT_INC_3M      32'd257698038
`define FBT_INC_6M      32'd515396076
`define FBT_INC_12M     32'd1030792151

// programmable ranges; slot, delays, quiet, setup and rotation in bit times
`define FBT_SLOT_MIN    24'd37
`define FBT_SLOT_MAX    24'd16383
`define FBT_SLOT_DEF    14'd300
`define FBT_MINSDR_MIN  24'd11
`define FBT_MINSDR_MAX  24'd1023
`define FBT_MINSDR_DEF  10'd11
`define FBT_MAXSDR_MIN  24'd37
`define FBT_MAXSDR_MAX  24'd1023
`define FBT_QUIET_MIN   24'd0
`define FBT_QUIET_MAX   24'd127
`define FBT_SETUP_MIN   24'd1
`define FBT_SETUP_MAX   24'd255
`define FBT_TTR_MIN     24'd256
`define FBT_TTR_MAX     24'd16777215
`define FBT_TTR_DEF     24'd50000
`define FBT_GAP_MIN     24'd1
`define FBT_GAP_MAX     24'd100
`define FBT_HIGH_STN_MIN 24'd2
`define FBT_HIGH_STN_MAX 24'd126
`define FBT_HIGH_STN_DEF 7'd126
`define FBT_RETRY_MIN   24'd1
`define FBT_RETRY_MAX   24'd7

// speed dependent defaults
`define FBT_MAXSDR_LOW  10'd60
`define FBT_MAXSDR_500K 10'd100
`define FBT_MAXSDR_1M5  10'd150
`define FBT_MAXSDR_3M   10'd250
`define FBT_MAXSDR_6M   10'd450
`define FBT_MAXSDR_12M  10'd800
`define FBT_QUIET_LOW   7'd0
`define FBT_QUIET_3M    7'd3
`define FBT_QUIET_6M    7'd6
`define FBT_QUIET_12M   7'd9
`define FBT_SETUP_LOW   8'd1
`define FBT_SETUP_3M    8'd4
`define FBT_SETUP_6M    8'd8
`define FBT_SETUP_12M   8'd16
`define FBT_GAP_DEF     7'd10
`define FBT_RETRY_LOW   3'd1
`define FBT_RETRY_HIGH  3'd3

`endif

// ===== fbt_pkg.sv
// Purpose: types of the fieldbus bus timing block
// Assumes: nothing
// Notes:   constants live in fbt_consts.svh
package fbt_pkg;
  typedef logic [3:0] fbt_speed_t;
  typedef enum logic [0:0] {FBT_IDLE, FBT_SLOT} fbt_state_t;
endpackage

// ===== fbt_bit_timer.sv
// Purpose: bit period tick generator for the selected speed
// Assumes: 50 MHz clock, speed code from a register on the same clock
// Notes:   phase accumulator, so non-integer periods average out to within the rounding of the increment
`timescale 1ns/100ps
`include "fbt_consts.svh"
module fbt_bit_timer
  import fbt_pkg::*;
#(
  parameter int ACC_W = 32
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // speed
  input  wire fbt_speed_t speed,
  // tick
  output logic            bit_tick
);
  // increments are scaled for a 32 bit accumulator; refuse any other width at elaboration
  if (ACC_W != 32) begin
    $error("fbt_bit_timer: increments are scaled for ACC_W of 32");
  end

  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic             tick_d;

  // increment per speed code; jitter is one clock, fine for counting bit times
  always_comb begin
    unique case (speed)
      `FBT_SPD_9K6:   inc = `FBT_INC_9K6;
      `FBT_SPD_19K2:  inc = `FBT_INC_19K2;
      `FBT_SPD_45K45: inc = `FBT_INC_45K45;
      `FBT_SPD_93K75: inc = `FBT_INC_93K75;
      `FBT_SPD_187K5: inc = `FBT_INC_187K5;
      `FBT_SPD_500K:  inc = `FBT_INC_500K;
      `FBT_SPD_1M5:   inc = `FBT_INC_1M5;
      `FBT_SPD_3M:    inc = `FBT_INC_3M;
      `FBT_SPD_6M:    inc = `FBT_INC_6M;
      default:        inc = `FBT_INC_12M;
    endcase
    {tick_d, acc_d} = {1'b0, acc_q} + {1'b0, inc};
  end

  // carry out of the accumulator is one bit period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q    <= '0;
      bit_tick <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      bit_tick <= tick_d;
    end
  end
endmodule

// ===== fbt_timing.sv
// Purpose: bus timing parameters of a fieldbus master and the logic applying them
// Assumes: 50 MHz clock; req_sent, resp_start, token_pass, slave_error come from logic on clk
// Notes:   configuration values are clamped into their legal range on load
`timescale 1ns/100ps
`include "fbt_consts.svh"
// Notes on behaviour
// - clear-on-error clears all slave outputs on error while the exchange request is held
// - speed 9.6k to 12M, default 1.5M
// - slot time 37..16383, default 300, timeout flag on expiry, error once the retries are used up
// - minimum responder delay 11..1023, default 11
// - maximum responder delay 37..1023
// - setup time 1..255, default 1
// - token rotation 256..16777215, default 50000, 24 bits
// - gap factor 1..100 sets gap update interval
// - highest station 2..126, default 126
// - retries limited to programmable 1..7
// - slot and rotation timers tick once per bit time; the gap counter counts token passes
// - speed dependent defaults for delays and times
module fbt_timing
  import fbt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // host control
  input  wire logic        exchange_start_request,
  input  wire logic        clear_on_error_en,
  input  wire logic        cfg_load,
  input  wire logic        defaults_load,
  // configuration values
  input  wire fbt_speed_t  cfg_speed,
  input  wire logic [13:0] cfg_slot,
  input  wire logic [9:0]  cfg_min_tsdr,
  input  wire logic [9:0]  cfg_max_tsdr,
  input  wire logic [6:0]  cfg_quiet,
  input  wire logic [7:0]  cfg_setup,
  input  wire logic [23:0] cfg_ttr,
  input  wire logic [6:0]  cfg_gap,
  input  wire logic [6:0]  cfg_high_stn,
  input  wire logic [2:0]  cfg_retry,
  // link events
  input  wire logic        req_sent,
  input  wire logic        resp_start,
  input  wire logic        token_pass,
  input  wire logic        slave_error,
  input  wire logic [6:0]  station_addr,
  // settings in force
  output fbt_speed_t       speed_q,
  output logic [13:0]      response_slot_timeout_q,
  output logic [9:0]       min_tsdr_q,
  output logic [9:0]       max_tsdr_q,
  output logic [6:0]       quiet_q,
  output logic [7:0]       setup_q,
  output logic [23:0]      target_token_rotation_q,
  output logic [6:0]       gap_q,
  output logic [6:0]       highest_station_number_q,
  output logic [2:0]       retry_q,
  // status
  output logic             bit_period_unit,
  output logic             slot_timeout_q,
  output logic             retry_req_q,
  output logic             comm_error_q,
  output logic             resp_early_q,
  output logic             clear_all_outputs_q,
  output logic             token_late_q,
  output logic             gap_update_q,
  output logic             station_in_range_q
);
  fbt_state_t  state_q, state_d;
  logic [13:0] slot_cnt_q, slot_cnt_d;
  logic [2:0]  retry_cnt_q, retry_cnt_d;
  logic [23:0] ttr_cnt_q, ttr_cnt_d;
  logic [6:0]  gap_cnt_q, gap_cnt_d;
  logic        xreq_m_q, xreq_s_q;
  logic        bit_tick;
  fbt_speed_t  speed_d, dspd;
  logic [13:0] slot_d;
  logic [9:0]  min_tsdr_d, max_tsdr_d;
  logic [6:0]  quiet_d, gap_d, high_stn_d;
  logic [7:0]  setup_d;
  logic [23:0] ttr_d;
  logic [2:0]  retry_d;
  logic        timeout_d, retry_req_d, comm_error_d, early_d, clear_d, late_d, gap_upd_d, err_event;
  function automatic logic [23:0] clampv(input logic [23:0] v, input logic [23:0] lo, input logic [23:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  // bit period tick for the speed in force
  fbt_bit_timer #(.ACC_W(32)) u_bit (
    .clk      (clk),
    .rst_b    (rst_b),
    .speed    (speed_q),
    .bit_tick (bit_tick)
  );
  // exchange request comes from the host pin: two flops first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xreq_m_q <= 1'b0;
      xreq_s_q <= 1'b0;
    end else begin
      xreq_m_q <= exchange_start_request;
      xreq_s_q <= xreq_m_q;
    end
  end
  // configuration: explicit load clamps, defaults load follows speed
  always_comb begin
    speed_d    = speed_q;
    slot_d     = response_slot_timeout_q;
    min_tsdr_d = min_tsdr_q;
    max_tsdr_d = max_tsdr_q;
    quiet_d    = quiet_q;
    setup_d    = setup_q;
    ttr_d      = target_token_rotation_q;
    gap_d      = gap_q;
    high_stn_d = highest_station_number_q;
    retry_d    = retry_q;
    dspd       = (cfg_speed > `FBT_SPD_12M) ? `FBT_SPD_12M : cfg_speed;
    if (cfg_load) begin
      speed_d    = dspd;
      slot_d     = 14'(clampv({10'h000, cfg_slot}, `FBT_SLOT_MIN, `FBT_SLOT_MAX));
      min_tsdr_d = 10'(clampv({14'h0000, cfg_min_tsdr}, `FBT_MINSDR_MIN, `FBT_MINSDR_MAX));
      max_tsdr_d = 10'(clampv({14'h0000, cfg_max_tsdr}, `FBT_MAXSDR_MIN, `FBT_MAXSDR_MAX));
      quiet_d    = 7'(clampv({17'h00000, cfg_quiet}, `FBT_QUIET_MIN, `FBT_QUIET_MAX));
      setup_d    = 8'(clampv({16'h0000, cfg_setup}, `FBT_SETUP_MIN, `FBT_SETUP_MAX));
      ttr_d      = clampv(cfg_ttr, `FBT_TTR_MIN, `FBT_TTR_MAX);
      gap_d      = 7'(clampv({17'h00000, cfg_gap}, `FBT_GAP_MIN, `FBT_GAP_MAX));
      high_stn_d = 7'(clampv({17'h00000, cfg_high_stn}, `FBT_HIGH_STN_MIN, `FBT_HIGH_STN_MAX));
      retry_d    = 3'(clampv({21'h000000, cfg_retry}, `FBT_RETRY_MIN, `FBT_RETRY_MAX));
    end else if (defaults_load) begin
      speed_d    = dspd;
      slot_d     = `FBT_SLOT_DEF;
      min_tsdr_d = `FBT_MINSDR_DEF;
      ttr_d      = `FBT_TTR_DEF;
      gap_d      = `FBT_GAP_DEF;
      high_stn_d = `FBT_HIGH_STN_DEF;
      retry_d    = (dspd > `FBT_SPD_1M5) ? `FBT_RETRY_HIGH : `FBT_RETRY_LOW;
      unique case (dspd)
        `FBT_SPD_500K: {max_tsdr_d, quiet_d, setup_d} = {`FBT_MAXSDR_500K, `FBT_QUIET_LOW, `FBT_SETUP_LOW};
        `FBT_SPD_1M5:  {max_tsdr_d, quiet_d, setup_d} = {`FBT_MAXSDR_1M5, `FBT_QUIET_LOW, `FBT_SETUP_LOW};
        `FBT_SPD_3M:   {max_tsdr_d, quiet_d, setup_d} = {`FBT_MAXSDR_3M, `FBT_QUIET_3M, `FBT_SETUP_3M};
        `FBT_SPD_6M:   {max_tsdr_d, quiet_d, setup_d} = {`FBT_MAXSDR_6M, `FBT_QUIET_6M, `FBT_SETUP_6M};
        `FBT_SPD_12M:  {max_tsdr_d, quiet_d, setup_d} = {`FBT_MAXSDR_12M, `FBT_QUIET_12M, `FBT_SETUP_12M};
        default:       {max_tsdr_d, quiet_d, setup_d} = {`FBT_MAXSDR_LOW, `FBT_QUIET_LOW, `FBT_SETUP_LOW};
      endcase
    end
  end
  // settings in force
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_q                  <= `FBT_SPD_DEFAULT;
      response_slot_timeout_q  <= `FBT_SLOT_DEF;
      min_tsdr_q               <= `FBT_MINSDR_DEF;
      max_tsdr_q               <= `FBT_MAXSDR_1M5;
      quiet_q                  <= `FBT_QUIET_LOW;
      setup_q                  <= `FBT_SETUP_LOW;
      target_token_rotation_q  <= `FBT_TTR_DEF;
      gap_q                    <= `FBT_GAP_DEF;
      highest_station_number_q <= `FBT_HIGH_STN_DEF;
      retry_q                  <= `FBT_RETRY_LOW;
    end else begin
      speed_q                  <= speed_d;
      response_slot_timeout_q  <= slot_d;
      min_tsdr_q               <= min_tsdr_d;
      max_tsdr_q               <= max_tsdr_d;
      quiet_q                  <= quiet_d;
      setup_q                  <= setup_d;
      target_token_rotation_q  <= ttr_d;
      gap_q                    <= gap_d;
      highest_station_number_q <= high_stn_d;
      retry_q                  <= retry_d;
    end
  end
  // response wait, retries, output clearing, token rotation and gap
  always_comb begin
    state_d      = state_q;
    slot_cnt_d   = slot_cnt_q;
    retry_cnt_d  = retry_cnt_q;
    timeout_d    = 1'b0;
    retry_req_d  = 1'b0;
    comm_error_d = 1'b0;
    early_d      = 1'b0;
    unique case (state_q)
      FBT_IDLE: begin
        if (req_sent && xreq_s_q) begin
          state_d    = FBT_SLOT;
          slot_cnt_d = '0;
        end
      end
      FBT_SLOT: begin
        if (resp_start) begin
          state_d     = FBT_IDLE;
          retry_cnt_d = '0;
          early_d     = ({4'h0, min_tsdr_q} > slot_cnt_q);
        end else if (bit_tick) begin
          if (slot_cnt_q + 14'h0001 >= response_slot_timeout_q) begin
            timeout_d = 1'b1;
            state_d   = FBT_IDLE;
            if (retry_cnt_q < retry_q) begin
              retry_req_d = 1'b1;
              retry_cnt_d = retry_cnt_q + 3'h1;
            end else begin
              comm_error_d = 1'b1;
              retry_cnt_d  = '0;
            end
          end else begin
            slot_cnt_d = slot_cnt_q + 14'h0001;
          end
        end
      end
    endcase
    err_event = comm_error_d || slave_error;
    // dropping the request releases the clear; a new error in the same cycle does not set it
    clear_d = xreq_s_q && clear_all_outputs_q;
    if (err_event && clear_on_error_en && xreq_s_q) clear_d = 1'b1;
    // rotation counter saturates at the target so a late token stays flagged
    ttr_cnt_d = ttr_cnt_q;
    gap_cnt_d = gap_cnt_q;
    gap_upd_d = 1'b0;
    if (token_pass) begin
      ttr_cnt_d = '0;
      if (gap_cnt_q + 7'h01 >= gap_q) begin
        gap_cnt_d = '0;
        gap_upd_d = 1'b1;
      end else begin
        gap_cnt_d = gap_cnt_q + 7'h01;
      end
    end else if (bit_tick && ttr_cnt_q < target_token_rotation_q) begin
      ttr_cnt_d = ttr_cnt_q + 24'h000001;
    end
    late_d = (ttr_cnt_d >= target_token_rotation_q);
  end
  // status flags and counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q             <= FBT_IDLE;
      slot_cnt_q          <= '0;
      retry_cnt_q         <= '0;
      ttr_cnt_q           <= '0;
      gap_cnt_q           <= '0;
      slot_timeout_q      <= 1'b0;
      retry_req_q         <= 1'b0;
      comm_error_q        <= 1'b0;
      resp_early_q        <= 1'b0;
      clear_all_outputs_q <= 1'b0;
      token_late_q        <= 1'b0;
      gap_update_q        <= 1'b0;
      station_in_range_q  <= 1'b0;
      bit_period_unit     <= 1'b0;
    end else begin
      state_q             <= state_d;
      slot_cnt_q          <= slot_cnt_d;
      retry_cnt_q         <= retry_cnt_d;
      ttr_cnt_q           <= ttr_cnt_d;
      gap_cnt_q           <= gap_cnt_d;
      slot_timeout_q      <= timeout_d;
      retry_req_q         <= retry_req_d;
      comm_error_q        <= comm_error_d;
      resp_early_q        <= early_d;
      clear_all_outputs_q <= clear_d;
      token_late_q        <= late_d;
      gap_update_q        <= gap_upd_d;
      station_in_range_q  <= (station_addr <= highest_station_number_q);
      bit_period_unit     <= bit_tick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence expire_s;
    state_q == FBT_SLOT && bit_tick && !resp_start && slot_cnt_q + 14'h0001 >= response_slot_timeout_q;
  endsequence

  clear_set_a: assert property (err_event && clear_on_error_en && xreq_s_q |=> clear_all_outputs_q)
    else $error("outputs not cleared after error");
  clear_hold_a: assert property (clear_all_outputs_q && xreq_s_q |=> clear_all_outputs_q)
    else $error("output clear released while request held");
  slot_expire_a: assert property (expire_s |=> slot_timeout_q && state_q == FBT_IDLE)
    else $error("slot expiry not flagged");
  slot_range_a: assert property (response_slot_timeout_q >= `FBT_SLOT_MIN)
    else $error("slot time below range");
  early_resp_a: assert property (state_q == FBT_SLOT && resp_start && slot_cnt_q < min_tsdr_q |=> resp_early_q)
    else $error("early response not flagged");
  ttr_range_a: assert property (target_token_rotation_q >= `FBT_TTR_MIN)
    else $error("rotation time below range");
  stn_range_a: assert property ($past(rst_b) |->
    station_in_range_q == ($past(station_addr) <= $past(highest_station_number_q)))
    else $error("station range compare wrong");
  retry_cap_a: assert property (retry_cnt_q <= retry_q || $changed(retry_q))
    else $error("retry count above limit");
  speed_load_a: assert property (cfg_load && cfg_speed <= `FBT_SPD_12M |=> speed_q == $past(cfg_speed))
    else $error("speed not loaded");
endmodule

// ===== fbt_resp_model.sv
// Purpose: responder station model on the link side of the timing block
// Assumes: answer delay is counted in bit period ticks after the request end
// Notes:   delay 0 keeps the station silent, so the slot wait has to run out
`timescale 1ns/100ps
module fbt_resp_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // request side
  input  wire logic       req_sent,
  input  wire logic       bit_tick,
  input  wire logic [9:0] delay,
  // answer
  output logic            resp_start
);
  int   cnt;
  logic busy;

  // answer once, only after the commanded delay, never earlier
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      busy <= 1'b0;
      resp_start <= 1'b0;
    end else begin
      resp_start <= 1'b0;
      if (req_sent && delay != 10'h000) begin
        busy <= 1'b1;
        cnt <= 0;
      end else if (busy && bit_tick) begin
        cnt <= cnt + 1;
        if (cnt + 1 >= int'(delay)) begin
          resp_start <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== fbt_timing_tb.sv
// Purpose: self-checking bench of the fieldbus bus timing block
// Assumes: 50 MHz clock, responder model on the link side
// Notes:   link tests run at 12M with short slot and rotation times
`timescale 1ns/100ps
module fbt_timing_tb;
  // stimulus
  logic        clk, rst_b, exchange_start_request, clear_on_error_en, cfg_load, defaults_load;
  logic [3:0]  cfg_speed;
  logic [13:0] cfg_slot;
  logic [9:0]  cfg_min_tsdr, cfg_max_tsdr, rdelay;
  logic [6:0]  cfg_quiet, cfg_gap, cfg_high_stn, station_addr;
  logic [7:0]  cfg_setup;
  logic [23:0] cfg_ttr;
  logic [2:0]  cfg_retry;
  logic        req_sent, resp_start, token_pass, slave_error;
  // observed
  logic [3:0]  speed_q;
  logic [13:0] response_slot_timeout_q;
  logic [9:0]  min_tsdr_q, max_tsdr_q;
  logic [6:0]  quiet_q, gap_q, highest_station_number_q;
  logic [7:0]  setup_q;
  logic [23:0] target_token_rotation_q;
  logic [2:0]  retry_q;
  logic        bit_period_unit, slot_timeout_q, retry_req_q, comm_error_q, resp_early_q;
  logic        clear_all_outputs_q, token_late_q, gap_update_q, station_in_range_q;
  logic        to, rr, ce, er;
  // model state
  int          fails = 0, checks_done = 0, cyc = 0, tk, e[10];
  int          mx[10] = '{60, 60, 60, 60, 60, 100, 150, 250, 450, 800};
  int          rate[10] = '{9600, 19200, 45450, 93750, 187500, 500000, 1500000, 3000000, 6000000, 12000000};

  fbt_timing u_fbt_timing (
    .clk, .rst_b, .exchange_start_request, .clear_on_error_en, .cfg_load, .defaults_load,
    .cfg_speed, .cfg_slot, .cfg_min_tsdr, .cfg_max_tsdr, .cfg_quiet, .cfg_setup, .cfg_ttr, .cfg_gap,
    .cfg_high_stn, .cfg_retry, .req_sent, .resp_start, .token_pass, .slave_error, .station_addr,
    .speed_q, .response_slot_timeout_q, .min_tsdr_q, .max_tsdr_q, .quiet_q, .setup_q,
    .target_token_rotation_q, .gap_q, .highest_station_number_q, .retry_q, .bit_period_unit,
    .slot_timeout_q, .retry_req_q, .comm_error_q, .resp_early_q, .clear_all_outputs_q,
    .token_late_q, .gap_update_q, .station_in_range_q
  );
  fbt_resp_model u_fbt_resp_model (.clk, .rst_b, .req_sent, .bit_tick(bit_period_unit), .delay(rdelay), .resp_start);

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_sim;
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  function automatic int clp(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction

  // one-cycle strobes; x adds further strobes in the same cycle
  task automatic strobe(input int w, input logic [4:0] x);
    @(posedge clk);
    {slave_error, token_pass, req_sent, defaults_load, cfg_load} <= (5'h01 << w) | x;
    @(posedge clk);
    {slave_error, token_pass, req_sent, defaults_load, cfg_load} <= 5'h00;
  endtask

  // load and clamp the expected settings into range
  task automatic do_load(input logic [4:0] x);
    strobe(0, x);
    e = '{clp(cfg_speed, 0, 9), clp(cfg_slot, 37, 16383), clp(cfg_min_tsdr, 11, 1023),
          clp(cfg_max_tsdr, 37, 1023), clp(cfg_quiet, 0, 127), clp(cfg_setup, 1, 255),
          clp(cfg_ttr, 256, 16777215), clp(cfg_gap, 1, 100), clp(cfg_high_stn, 2, 126), clp(cfg_retry, 1, 7)};
  endtask

  task automatic chk_set;
    @(negedge clk);
    check(speed_q, e[0]);
    check(response_slot_timeout_q, e[1]);
    check(min_tsdr_q, e[2]);
    check(max_tsdr_q, e[3]);
    check(quiet_q, e[4]);
    check(setup_q, e[5]);
    check(target_token_rotation_q, e[6]);
    check(gap_q, e[7]);
    check(highest_station_number_q, e[8]);
    check(retry_q, e[9]);
  endtask

  // one request; the window is wider than slot time at 12M
  task automatic slot_try(input int dly);
    {to, rr, ce, er} = 4'h0;
    tk = 0;
    @(posedge clk);
    rdelay <= 10'(dly);
    strobe(2, 5'h00);
    repeat (300) begin
      @(negedge clk);
      if (bit_period_unit && !to)
        tk++;
      {to, rr, ce, er} = {to, rr, ce, er} | {slot_timeout_q, retry_req_q, comm_error_q, resp_early_q};
    end
  endtask

  // host restarts output by dropping and raising the request
  task automatic restart;
    @(posedge clk);
    exchange_start_request <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check(clear_all_outputs_q, 0);
    @(posedge clk);
    exchange_start_request <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_ticks(input int n);
    while (tk < n) begin
      @(negedge clk);
      if (bit_period_unit)
        tk++;
    end
  endtask

  initial begin
    int c, n, d;
    void'($urandom(43));
    {exchange_start_request, clear_on_error_en, cfg_load, defaults_load, cfg_speed, cfg_slot, cfg_min_tsdr,
     cfg_max_tsdr, cfg_quiet, cfg_setup, cfg_ttr, cfg_gap, cfg_high_stn, cfg_retry, req_sent, token_pass,
     slave_error, station_addr, rdelay} = '0;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    e = '{6, 300, 11, 150, 0, 1, 50000, 10, 126, 1};
    chk_set;
    done("reset values");
    // speed dependent defaults for every speed code
    for (int s = 0; s < 10; s++) begin
      @(posedge clk);
      cfg_speed <= 4'(s);
      strobe(1, 5'h00);
      e[0] = s;
      e[3] = mx[s];
      e[4] = s < 7 ? 0 : 3 * (s - 6);
      e[5] = s < 7 ? 1 : 4 << (s - 7);
      e[7] = 10;
      e[9] = s < 7 ? 1 : 3;
      chk_set;
    end
    done("defaults");
    // random values, many out of range; a same-cycle defaults load must lose
    repeat (12) begin
      @(posedge clk);
      {cfg_speed, cfg_slot, cfg_min_tsdr, cfg_max_tsdr, cfg_quiet, cfg_setup} <= 53'({$urandom, $urandom});
      {cfg_ttr, cfg_gap, cfg_high_stn, cfg_retry} <= 41'({$urandom, $urandom});
      do_load({3'h0, 1'($urandom), 1'b0});
      chk_set;
    end
    done("clamp");
    // bit period length, first tick to tick n+1
    for (int s = 0; s < 10; s++) begin
      @(posedge clk);
      cfg_speed <= 4'(s);
      do_load(5'h00);
      n = s < 4 ? 2 : 8;
      c = 0;
      tk = 0;
      while (tk <= n) begin
        @(negedge clk);
        if (bit_period_unit)
          tk++;
        if (tk > 0)
          c++;
      end
      d = c - 1 - n * 50000000 / rate[s];
      check(d >= -1 && d <= 1, 1);
    end
    done("bit period");
    // link settings: 12M, slot 37, min 11, retry 2, rotation 256, gap 3
    @(posedge clk);
    {cfg_speed, cfg_slot, cfg_min_tsdr, cfg_max_tsdr} <= {4'h9, 14'h0025, 10'h00b, 10'h025};
    {cfg_quiet, cfg_setup, cfg_ttr, cfg_gap, cfg_retry} <= {7'h00, 8'h01, 24'h000100, 7'h03, 3'h2};
    exchange_start_request <= 1'b1;
    clear_on_error_en <= 1'b1;
    do_load(5'h00);
    chk_set;
    repeat (4) @(posedge clk);
    slot_try(0);
    check(tk >= 36 && tk <= 38, 1);
    check({to, rr, ce}, 3'b110);
    slot_try(0);
    check({to, rr, ce}, 3'b110);
    slot_try(0);
    check({to, rr, ce, clear_all_outputs_q}, 4'b1011);
    restart;
    slot_try(20);
    check({to, er}, 2'b00);
    slot_try(5);
    check({to, er}, 2'b01);
    slot_try(0);
    check({rr, ce}, 2'b10);
    done("slot and retry");
    // slave error clears all outputs only when enabled
    @(posedge clk);
    clear_on_error_en <= 1'b0;
    strobe(4, 5'h00);
    repeat (2) @(negedge clk);
    check(clear_all_outputs_q, 0);
    @(posedge clk);
    clear_on_error_en <= 1'b1;
    strobe(4, 5'h00);
    repeat (2) @(negedge clk);
    check(clear_all_outputs_q, 1);
    restart;
    done("clear on error");
    // rotation target and gap update interval
    strobe(3, 5'h00);
    tk = 0;
    wait_ticks(250);
    check(token_late_q, 0);
    wait_ticks(262);
    check(token_late_q, 1);
    n = 0;
    repeat (6) begin
      strobe(3, 5'h00);
      repeat (3) begin
        @(negedge clk);
        n += int'(gap_update_q);
      end
    end
    check(n, 2);
    done("token");
    // station range against the highest station number
    repeat (8) begin
      @(posedge clk);
      station_addr <= 7'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(station_in_range_q, station_addr <= e[8]);
    end
    done("station range");
    end_sim;
  end
endmodule
